// ---- logic/alarm_rearm_pkg.sv ----
package alarm_rearm_pkg;

  // ------------------------------------------------------------------
  // parameter store layout
  // ------------------------------------------------------------------
  localparam int             PARAM_W    = 16;
  localparam int             NUM_PARAMS = 10;
  localparam int             IDX_W      = 4;
  localparam int             NUM_ALARMS = 3;
  localparam int             TYPE_W     = 4;

  localparam logic [3:0]     IDX_ALM1_TYPE = 4'h0;
  localparam logic [3:0]     IDX_ALM2_TYPE = 4'h1;
  localparam logic [3:0]     IDX_ALM3_TYPE = 4'h2;
  localparam logic [3:0]     IDX_REARM_SEL = 4'h3;
  localparam logic [3:0]     IDX_RUN       = 4'h4;
  localparam logic [3:0]     IDX_PROG_NUM  = 4'h5;
  localparam logic [3:0]     IDX_SEG_SP    = 4'h6;
  localparam logic [3:0]     IDX_SHIFT     = 4'h7;
  localparam logic [3:0]     IDX_SHIFT_HI  = 4'h8;
  localparam logic [3:0]     IDX_SHIFT_LO  = 4'h9;

  // ------------------------------------------------------------------
  // default values
  // ------------------------------------------------------------------
  localparam logic [15:0]    DEF_ALM_TYPE  = 16'h0002;
  localparam logic [15:0]    DEF_REARM_SEL = 16'h0000;
  localparam logic [15:0]    DEF_RUN       = 16'h0000;
  localparam logic [15:0]    DEF_PROG_NUM  = 16'h0000;
  localparam logic [15:0]    DEF_OTHER     = 16'h0000;

  // ------------------------------------------------------------------
  // field codes
  // ------------------------------------------------------------------
  localparam logic           SEL_A       = 1'b0;
  localparam logic           SEL_B       = 1'b1;
  localparam logic           CMD_OFF     = 1'b0;
  localparam logic           CMD_RESTORE = 1'b1;
  localparam logic           RUN_RESET   = 1'b0;
  localparam logic           RUN_RUN     = 1'b1;

  localparam logic [3:0]     ALM_SB_5  = 4'h5;
  localparam logic [3:0]     ALM_SB_6  = 4'h6;
  localparam logic [3:0]     ALM_SB_7  = 4'h7;
  localparam logic [3:0]     ALM_SB_10 = 4'hA;
  localparam logic [3:0]     ALM_SB_11 = 4'hB;

  localparam logic [2:0]     LVL_OPERATION = 3'h0;
  localparam logic [2:0]     LVL_ADJUST    = 3'h1;
  localparam logic [2:0]     LVL_PROGRAM   = 3'h2;
  localparam logic [2:0]     LVL_INITIAL   = 3'h3;
  localparam logic [2:0]     LVL_COMMS     = 3'h4;
  localparam logic [2:0]     LVL_ADVANCED  = 3'h5;
  localparam logic [2:0]     LVL_CALIB     = 3'h6;
  localparam logic [2:0]     LVL_PROTECT   = 3'h7;

  typedef enum logic [0:0] {
    SEQ_IDLE  = 1'b0,
    SEQ_SWEEP = 1'b1
  } seq_state_t;

  function automatic logic [15:0] default_of(input logic [3:0] idx);
    logic [15:0] v;
    v = DEF_OTHER;
    if (idx == IDX_ALM1_TYPE || idx == IDX_ALM2_TYPE || idx == IDX_ALM3_TYPE)
      v = DEF_ALM_TYPE;
    else if (idx == IDX_REARM_SEL)
      v = DEF_REARM_SEL;
    else if (idx == IDX_RUN)
      v = DEF_RUN;
    else if (idx == IDX_PROG_NUM)
      v = DEF_PROG_NUM;
    return v;
  endfunction

  function automatic logic is_standby_type(input logic [3:0] t);
    return (t == ALM_SB_5) || (t == ALM_SB_6) || (t == ALM_SB_7) ||
           (t == ALM_SB_10) || (t == ALM_SB_11);
  endfunction

  function automatic logic is_setting_level(input logic [2:0] lvl);
    return (lvl == LVL_INITIAL) || (lvl == LVL_COMMS) ||
           (lvl == LVL_ADVANCED) || (lvl == LVL_CALIB);
  endfunction

endpackage

// ---- logic/restore_sequencer.sv ----
`timescale 1ns/1ps
module restore_sequencer
#(
  parameter int N     = 10,
  parameter int IDX_W = 4
)
(
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // control
  input  wire logic             start_i,
  output logic                  busy_o,
  output logic                  done_o,
  // store write port
  output logic                  wr_o,
  output logic [IDX_W-1:0]      idx_o
);

  localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(N - 1);

  alarm_rearm_pkg::seq_state_t state_reg;
  alarm_rearm_pkg::seq_state_t state_next;
  logic [IDX_W-1:0]            idx_reg;
  logic [IDX_W-1:0]            idx_next;
  logic                        done_reg;
  logic                        done_next;

  // ------------------------------------------------------------------
  // one default written per cycle
  // ------------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    idx_next   = idx_reg;
    done_next  = 1'b0;
    case (state_reg)
      alarm_rearm_pkg::SEQ_IDLE:
      begin
        if (start_i)
        begin
          state_next = alarm_rearm_pkg::SEQ_SWEEP;
          idx_next   = '0;
        end
      end
      alarm_rearm_pkg::SEQ_SWEEP:
      begin
        if (idx_reg == LAST_IDX)
        begin
          state_next = alarm_rearm_pkg::SEQ_IDLE;
          done_next  = 1'b1;
        end
        else
          idx_next = idx_reg + 1'b1;
      end
      default:
        state_next = alarm_rearm_pkg::SEQ_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg <= alarm_rearm_pkg::SEQ_IDLE;
      idx_reg   <= '0;
      done_reg  <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      idx_reg   <= idx_next;
      done_reg  <= done_next;
    end
  end

  assign busy_o = (state_reg == alarm_rearm_pkg::SEQ_SWEEP);
  assign wr_o   = busy_o;
  assign idx_o  = idx_reg;
  assign done_o = done_reg;

endmodule // restore_sequencer

// ---- logic/standby_channel.sv ----
`timescale 1ns/1ps
module standby_channel
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // control
  input  wire logic standby_en_i,
  input  wire logic rearm_i,
  input  wire logic force_off_i,
  input  wire logic cond_i,
  // status
  output logic      armed_o,
  output logic      alarm_o
);

  logic armed_reg;
  logic armed_next;
  logic alarm_reg;
  logic alarm_next;

  // ------------------------------------------------------------------
  // standby: suppress until the value has once left the alarm region
  // ------------------------------------------------------------------
  always_comb
  begin
    armed_next = armed_reg;
    if (rearm_i)
      armed_next = 1'b1;
    else if (armed_reg && !cond_i)
      armed_next = 1'b0;
    alarm_next = cond_i;
    if (standby_en_i && armed_reg)
      alarm_next = 1'b0;
    if (force_off_i)
      alarm_next = 1'b0;
  end

  // power-up leaves the standby armed
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      armed_reg <= 1'b1;
      alarm_reg <= 1'b0;
    end
    else
    begin
      armed_reg <= armed_next;
      alarm_reg <= alarm_next;
    end
  end

  assign armed_o = armed_reg;
  assign alarm_o = alarm_reg;

endmodule // standby_channel

// ---- logic/alarm_standby_rearm_and_init.sv ----
`timescale 1ns/1ps
// Summary of operation
// - writing the restore choice to param_restore_cmd loads every stored setting with its default, off changes nothing and is the default.
// - when the restore sweep finishes param_restore_cmd returns to off by itself.
// - the standby sequence only acts on alarms 1 to 3 whose type is 5, 6, 7, 10 or 11.
// - standby_rearm_select picks event set A or the power-on-only set B as re-arm causes.
// - alarm outputs are forced off while in the initial, comms, advanced or calibration level.
// - under set A the standby re-arms at the start of operation, power-up included.
// - under set A a run/reset change from reset to run re-arms the standby.
// - under set A every program start, repeat or link included, re-arms the standby.
// - under set A every segment change, advance included, re-arms the standby.
// - under set A a change of program number re-arms the standby.
// - under set A a change of the current segment set point or fixed set point re-arms the standby.
// - under set A a change of any input shift value re-arms the standby.
module alarm_standby_rearm_and_init
#(
  parameter int NUM_ALARMS = alarm_rearm_pkg::NUM_ALARMS,
  parameter int NUM_PARAMS = alarm_rearm_pkg::NUM_PARAMS
)
(
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // setting writes and reads
  input  wire logic                 set_wr_i,
  input  wire logic [3:0]           set_idx_i,
  input  wire logic [15:0]          set_data_i,
  input  wire logic [3:0]           rd_idx_i,
  output logic      [15:0]          rd_data_o,
  // restore command
  input  wire logic                 cmd_wr_i,
  input  wire logic                 cmd_val_i,
  output logic                      param_restore_cmd_o,
  output logic                      init_busy_o,
  // operating events
  input  wire logic [2:0]           level_i,
  input  wire logic                 prog_start_i,
  input  wire logic                 seg_change_i,
  // alarms
  input  wire logic [NUM_ALARMS-1:0] alarm_cond_i,
  output logic      [NUM_ALARMS-1:0] alarm_o,
  output logic      [NUM_ALARMS-1:0] standby_armed_o
);

  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  logic [15:0]           param_reg [NUM_PARAMS];
  logic [15:0]           param_next [NUM_PARAMS];
  logic                  cmd_reg;
  logic                  cmd_next;
  logic                  pwr_reg;
  logic                  rearm_reg;
  logic                  rearm_next;
  logic [15:0]           rd_reg;
  logic [15:0]           rd_next;
  logic                  busy_reg;
  logic                  seq_start;
  logic                  seq_busy;
  logic                  seq_done;
  logic                  seq_wr;
  logic [3:0]            seq_idx;
  logic                  wr_en;
  logic [3:0]            wr_idx;
  logic [15:0]           wr_data;
  logic                  changed;
  logic                  run_start;
  logic                  sp_chg;
  logic                  shift_chg;
  logic                  prog_chg;
  logic                  sel_a;
  logic                  force_off;
  logic [NUM_ALARMS-1:0] standby_en;

  // ------------------------------------------------------------------
  // restore command
  // ------------------------------------------------------------------
  assign seq_start = cmd_wr_i && (cmd_val_i == alarm_rearm_pkg::CMD_RESTORE) &&
                     !cmd_reg && !seq_busy;

  always_comb
  begin
    cmd_next = cmd_reg;
    if (seq_start)
      cmd_next = alarm_rearm_pkg::CMD_RESTORE;
    else if (seq_done)
      cmd_next = alarm_rearm_pkg::CMD_OFF;
  end

  restore_sequencer
  #(
    .N     (NUM_PARAMS),
    .IDX_W (alarm_rearm_pkg::IDX_W)
  )
  u_seq
  (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (seq_start),
    .busy_o  (seq_busy),
    .done_o  (seq_done),
    .wr_o    (seq_wr),
    .idx_o   (seq_idx)
  );

  // ------------------------------------------------------------------
  // parameter store
  // ------------------------------------------------------------------
  // host writes are dropped while a restore is pending or running
  always_comb
  begin
    wr_en   = set_wr_i && !cmd_reg && !seq_busy;
    wr_idx  = set_idx_i;
    wr_data = set_data_i;
    if (seq_wr)
    begin
      wr_en   = 1'b1;
      wr_idx  = seq_idx;
      wr_data = alarm_rearm_pkg::default_of(seq_idx);
    end
  end

  always_comb
  begin
    for (int i = 0; i < NUM_PARAMS; i++)
      param_next[i] = param_reg[i];
    if (wr_en && (int'(wr_idx) < NUM_PARAMS))
      param_next[wr_idx] = wr_data;
    rd_next = 16'h0000;
    if (int'(rd_idx_i) < NUM_PARAMS)
      rd_next = param_reg[rd_idx_i];
  end

  // ------------------------------------------------------------------
  // re-arm events
  // ------------------------------------------------------------------
  always_comb
  begin
    changed   = wr_en && (int'(wr_idx) < NUM_PARAMS) && (param_reg[wr_idx] != wr_data);
    run_start = changed && (wr_idx == alarm_rearm_pkg::IDX_RUN) &&
                (wr_data[0] == alarm_rearm_pkg::RUN_RUN) &&
                (param_reg[alarm_rearm_pkg::IDX_RUN][0] == alarm_rearm_pkg::RUN_RESET);
    prog_chg  = changed && (wr_idx == alarm_rearm_pkg::IDX_PROG_NUM);
    sp_chg    = changed && (wr_idx == alarm_rearm_pkg::IDX_SEG_SP);
    shift_chg = changed && ((wr_idx == alarm_rearm_pkg::IDX_SHIFT) ||
                            (wr_idx == alarm_rearm_pkg::IDX_SHIFT_HI) ||
                            (wr_idx == alarm_rearm_pkg::IDX_SHIFT_LO));
    sel_a     = (param_reg[alarm_rearm_pkg::IDX_REARM_SEL][0] == alarm_rearm_pkg::SEL_A);
    // set B: only the power-up reset value of each channel re-arms it
    rearm_next = sel_a && (pwr_reg || run_start || prog_start_i || seg_change_i ||
                           prog_chg || sp_chg || shift_chg);
  end

  assign force_off = alarm_rearm_pkg::is_setting_level(level_i);

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < NUM_PARAMS; i++)
        param_reg[i] <= 16'h0000;
      cmd_reg   <= alarm_rearm_pkg::CMD_OFF;
      pwr_reg   <= 1'b1;
      rearm_reg <= 1'b0;
      rd_reg    <= 16'h0000;
      busy_reg  <= 1'b0;
    end
    else
    begin
      // first clocked cycle loads defaults, standing in for power-on
      for (int i = 0; i < NUM_PARAMS; i++)
        param_reg[i] <= pwr_reg ? alarm_rearm_pkg::default_of(4'(i)) : param_next[i];
      cmd_reg   <= cmd_next;
      pwr_reg   <= 1'b0;
      rearm_reg <= rearm_next;
      rd_reg    <= rd_next;
      busy_reg  <= seq_busy || seq_start;
    end
  end

  // ------------------------------------------------------------------
  // alarm channels
  // ------------------------------------------------------------------
  for (genvar k = 0; k < NUM_ALARMS; k++)
  begin : g_alarm
    assign standby_en[k] = alarm_rearm_pkg::is_standby_type(
                             param_reg[alarm_rearm_pkg::IDX_ALM1_TYPE + 4'(k)][3:0]);

    standby_channel u_chan
    (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .standby_en_i (standby_en[k]),
      .rearm_i      (rearm_reg),
      .force_off_i  (force_off),
      .cond_i       (alarm_cond_i[k]),
      .armed_o      (standby_armed_o[k]),
      .alarm_o      (alarm_o[k])
    );
  end

  assign param_restore_cmd_o = cmd_reg;
  assign init_busy_o         = busy_reg;
  assign rd_data_o           = rd_reg;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_restore_loads_default: assert property (seq_wr |=>
    param_reg[$past(seq_idx)] == alarm_rearm_pkg::default_of($past(seq_idx)))
    else $error("restore did not load default");

  a_off_leaves_idle: assert property ((cmd_wr_i && cmd_val_i == alarm_rearm_pkg::CMD_OFF
    && !cmd_reg && !seq_busy) |=> !seq_busy && !cmd_reg)
    else $error("off choice started a restore");

  a_cmd_self_clears: assert property ($rose(cmd_reg) |-> ##[1:12] $fell(cmd_reg))
    else $error("restore command did not clear itself");

  a_clear_after_done: assert property (seq_done |=> !cmd_reg)
    else $error("command still set after restore");

  a_plain_type_passes: assert property ((!standby_en[0] && !force_off) |=>
    alarm_o[0] == $past(alarm_cond_i[0]))
    else $error("non-standby alarm was suppressed");

  a_rearm_needs_a: assert property (rearm_reg |-> $past(sel_a))
    else $error("re-arm with set B selected");

  a_level_forces_off: assert property (force_off |=> alarm_o == '0)
    else $error("alarm not forced off in setting level");

  a_powerup_rearm: assert property ((pwr_reg && sel_a) |=> rearm_reg)
    else $error("no re-arm at start of operation");

  a_run_rearm: assert property ((run_start && sel_a) |=> rearm_reg ##1 standby_armed_o == '1)
    else $error("reset to run did not re-arm");

  a_prog_start_rearm: assert property ((prog_start_i && sel_a) |=> rearm_reg)
    else $error("program start did not re-arm");

  a_segment_rearm: assert property ((seg_change_i && sel_a) |=> rearm_reg)
    else $error("segment change did not re-arm");

  a_prog_num_rearm: assert property ((prog_chg && sel_a) |=> rearm_reg)
    else $error("program number change did not re-arm");

  a_sp_rearm: assert property ((sp_chg && sel_a) |=> rearm_reg)
    else $error("set point change did not re-arm");

  a_shift_rearm: assert property ((shift_chg && sel_a) |=> rearm_reg)
    else $error("input shift change did not re-arm");

  a_set_b_quiet: assert property (!sel_a |=> !rearm_reg)
    else $error("set B re-armed on an event");

  a_start_on_restore: assert property ($rose(cmd_reg) |->
    $past(cmd_wr_i && cmd_val_i == alarm_rearm_pkg::CMD_RESTORE))
    else $error("restore started without a restore write");

  a_busy_follows_sweep: assert property (seq_busy |=> init_busy_o)
    else $error("busy flag missing during sweep");

  a_done_ends_sweep: assert property (seq_done |-> !seq_busy)
    else $error("sweep still running after done");

  a_standby_suppresses: assert property ((standby_en[0] && standby_armed_o[0]) |=>
    !alarm_o[0])
    else $error("armed standby alarm was not suppressed");

  a_rearm_arms_all: assert property (rearm_reg |=> standby_armed_o == '1)
    else $error("re-arm pulse did not arm the channels");

  c_restore_done: cover property ($rose(cmd_reg) ##[1:12] $fell(cmd_reg));
  c_rearm_a:      cover property (sel_a && seg_change_i ##1 rearm_reg);
  c_standby_out:  cover property (standby_en[0] && standby_armed_o[0] ##[1:20] alarm_o[0]);
  c_forced_off:   cover property (alarm_o[1] ##1 force_off ##1 !alarm_o[1]);
  c_set_b_event:  cover property (!sel_a && seg_change_i ##1 !rearm_reg);

endmodule // alarm_standby_rearm_and_init

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  // ------------------------------------------------------------------
  // stimulus, observed outputs and model state
  // ------------------------------------------------------------------
  logic        clk_i        = 1'b0;
  logic        rst_i        = 1'b1;
  logic        set_wr_i     = 1'b0;
  logic [3:0]  set_idx_i    = 4'h0;
  logic [15:0] set_data_i   = 16'h0000;
  logic [3:0]  rd_idx_i     = 4'h0;
  logic        cmd_wr_i     = 1'b0;
  logic        cmd_val_i    = 1'b0;
  logic [2:0]  level_i      = 3'h0;
  logic        prog_start_i = 1'b0;
  logic        seg_change_i = 1'b0;
  logic [2:0]  alarm_cond_i = 3'h7;
  logic [15:0] rd_data_o;
  logic        param_restore_cmd_o;
  logic        init_busy_o;
  logic [2:0]  alarm_o;
  logic [2:0]  standby_armed_o;
  int          miscompares  = 0;
  int          n_tests      = 0;
  int          cycles       = 0;
  integer      seed         = 32'h3D5F3F58;
  logic [15:0] mem [10];
  logic [2:0]  armed;
  logic        sel_b;
  logic        pend         = 1'b0;

  always #10 clk_i = ~clk_i;

  alarm_standby_rearm_and_init dut
  (
    .clk_i               (clk_i),
    .rst_i               (rst_i),
    .set_wr_i            (set_wr_i),
    .set_idx_i           (set_idx_i),
    .set_data_i          (set_data_i),
    .rd_idx_i            (rd_idx_i),
    .rd_data_o           (rd_data_o),
    .cmd_wr_i            (cmd_wr_i),
    .cmd_val_i           (cmd_val_i),
    .param_restore_cmd_o (param_restore_cmd_o),
    .init_busy_o         (init_busy_o),
    .level_i             (level_i),
    .prog_start_i        (prog_start_i),
    .seg_change_i        (seg_change_i),
    .alarm_cond_i        (alarm_cond_i),
    .alarm_o             (alarm_o),
    .standby_armed_o     (standby_armed_o)
  );

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic end_sim;
    $display("tests run %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: run took too long", $time);
      end_sim;
    end
  end

  function automatic logic sb(logic [15:0] t);
    return t[3:0] == 4'h5 || t[3:0] == 4'h6 || t[3:0] == 4'h7 ||
           t[3:0] == 4'hA || t[3:0] == 4'hB;
  endfunction

  task automatic tick(int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic cmp(logic [15:0] got, logic [15:0] exp, string what);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic do_reset;
    rst_i = 1'b1;
    tick(10);
    rst_i = 1'b0;
    for (int i = 0; i < 10; i++)
      mem[i] = (i < 3) ? 16'h0002 : 16'h0000;
    armed = 3'h7;
    sel_b = 1'b0;
    tick(2);
  endtask

  // one write strobe; the model decides whether it is a re-arm cause
  task automatic wr(int idx, logic [15:0] d);
    set_wr_i   = 1'b1;
    set_idx_i  = 4'(idx);
    set_data_i = d;
    tick(1);
    set_wr_i   = 1'b0;
    // one idle edge, so a following call never raises the strobe in the same step
    tick(1);
    if (idx < 10 && !pend)
    begin
      if (!sel_b && ((idx > 4 && mem[idx] != d) || (idx == 4 && !mem[4][0] && d[0])))
        armed = 3'h7;
      if (idx == 3)
        sel_b = d[0];
      mem[idx] = d;
    end
  endtask

  task automatic pulse(int which);
    prog_start_i = (which == 0);
    seg_change_i = (which == 1);
    tick(1);
    prog_start_i = 1'b0;
    seg_change_i = 1'b0;
    if (!sel_b)
      armed = 3'h7;
  endtask

  task automatic disarm;
    alarm_cond_i = 3'h0;
    tick(3);
    alarm_cond_i = 3'h7;
    tick(3);
    armed = 3'h0;
  endtask

  task automatic chk_alarm;
    logic [2:0] ea;
    logic [2:0] m;
    tick(3);
    for (int k = 0; k < 3; k++)
    begin
      m[k]  = sb(mem[k]);
      ea[k] = alarm_cond_i[k] && !(m[k] && armed[k]) && !(level_i inside {[3:6]});
    end
    cmp({13'h0000, alarm_o}, {13'h0000, ea}, "alarm outputs");
    cmp({13'h0000, standby_armed_o & m}, {13'h0000, armed & m}, "standby armed");
  endtask

  task automatic chk_reg(int i);
    rd_idx_i = 4'(i);
    tick(2);
    cmp(rd_data_o, (i < 10) ? mem[i] : 16'h0000, "setting readback");
  endtask

  // fixed pass over every event kind, then random events and values
  task automatic ev_loop(int n);
    int          op;
    logic [15:0] d;
    for (int j = 0; j < n; j++)
    begin
      op = (j < 8) ? j : int'($unsigned($random(seed)) % 8);
      d  = 16'($random(seed));
      if ($random(seed) & 1)
        d = mem[op + 2];
      if (op < 2)
        pulse(op);
      else
        wr(op + 2, d);
      chk_alarm;
      disarm;
    end
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial
  begin
    do_reset;
    for (int i = 0; i < 16; i++)
      chk_reg(i);
    cmp({15'h0000, param_restore_cmd_o}, 16'h0000, "restore idle");
    wr(12, 16'h00AA);
    chk_reg(12);
    wr(0, 16'h0005);
    wr(1, 16'h000A);
    wr(2, 16'h0002);
    chk_alarm;
    disarm;
    chk_alarm;
    $display("test power_on and types done");
    ev_loop(24);
    $display("test event set A done");
    for (int l = 0; l < 8; l++)
    begin
      level_i = 3'(l);
      chk_alarm;
    end
    level_i = 3'h0;
    $display("test level force off done");
    wr(3, 16'h0001);
    ev_loop(16);
    do_reset;
    wr(0, 16'h0007);
    wr(1, 16'h000B);
    wr(2, 16'h0006);
    chk_alarm;
    $display("test event set B done");
    wr(3, 16'h0001);
    wr(5, 16'h1234);
    cmd_val_i = 1'b0;
    cmd_wr_i  = 1'b1;
    tick(1);
    cmd_wr_i  = 1'b0;
    tick(3);
    cmp({15'h0000, param_restore_cmd_o}, 16'h0000, "off choice");
    chk_reg(5);
    cmd_val_i = 1'b1;
    cmd_wr_i  = 1'b1;
    tick(1);
    cmd_wr_i  = 1'b0;
    for (int w = 0; w < 5 && param_restore_cmd_o !== 1'b1; w++)
      tick(1);
    cmp({15'h0000, param_restore_cmd_o}, 16'h0001, "restore pending");
    cmp({15'h0000, init_busy_o}, 16'h0001, "restore running");
    pend = 1'b1;
    wr(6, 16'h00FF);
    for (int w = 0; w < 40 && param_restore_cmd_o !== 1'b0; w++)
      tick(1);
    pend = 1'b0;
    cmp({15'h0000, param_restore_cmd_o}, 16'h0000, "command self clear");
    cmp({15'h0000, init_busy_o}, 16'h0000, "sweep finished");
    for (int i = 0; i < 10; i++)
      mem[i] = (i < 3) ? 16'h0002 : 16'h0000;
    sel_b = 1'b0;
    for (int i = 0; i < 10; i++)
      chk_reg(i);
    chk_alarm;
    $display("test restore defaults done");
    end_sim;
  end

endmodule // testbench
